// >>> bench/dpc_clock_control_chk.sv
// checker: bus handshake and timestamp mode assertions at the clock control ports
module dpc_clock_control_chk import dpc_pkg::*; (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic        clkEn,
  // register bus
  input wire dpc_wb_req_t wbReq,
  input wire logic        wbAck,
  // controls
  input wire dpc_ts_ctl_t tsCtl,
  input wire logic [31:0] loopBandwidth
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // a request counts only while enabled and not already answered
  logic taken;
  assign taken = wbReq.cyc && wbReq.stb && clkEn && !wbAck;

  a_ack_single: assert property (wbAck |=> !wbAck) else $error("ack longer than one cycle");
  a_ack_answers: assert property (taken |=> wbAck) else $error("request not answered next edge");
  a_ack_cause: assert property (wbAck |-> $past(wbReq.cyc && wbReq.stb)) else $error("ack without request");
  a_bw_range: assert property (loopBandwidth >= LOOP_BW_MIN && loopBandwidth <= LOOP_BW_MAX)
    else $error("bandwidth out of range");
  a_pair_legal: assert property ((tsCtl.clkSel == SRC_LINE_PLL && tsCtl.tsMode == TS_HYBRID) ||
    (tsCtl.clkSel == SRC_SEC_PLL && tsCtl.tsMode == TS_SW_RATE) || tsCtl.clkSel == SRC_SYNTH2)
    else $error("illegal source and mode pair");
  a_rate_mode: assert property (tsCtl.rateEn == (tsCtl.tsMode == TS_SW_RATE))
    else $error("rate enable not tied to mode");
  a_time_adj: assert property (tsCtl.timeAdjStb |-> tsCtl.tsMode inside {TS_HYBRID, TS_SW_RATE})
    else $error("time strobe in wrong mode");
  a_phase_adj: assert property (tsCtl.phaseAdjStb |-> tsCtl.tsMode inside {TS_DCO, TS_ENSEMBLE})
    else $error("phase strobe in wrong mode");
  a_adj_follows: assert property ((taken && wbReq.we && wbReq.adr == TS_ADJ_OFS) |->
    ##[1:2] (tsCtl.timeAdjStb || tsCtl.phaseAdjStb)) else $error("adjust write gave no strobe");
  a_sel_cause: assert property ($changed(tsCtl.clkSel) |->
    $past(wbReq.cyc && wbReq.we && wbReq.adr == CLK_SEL_OFS)) else $error("source changed without write");
endmodule // dpc_clock_control_chk

bind dpc_clock_control dpc_clock_control_chk u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .wbReq(wbReq), .wbAck(wbAck),
  .tsCtl(tsCtl), .loopBandwidth(loopBandwidth)
);

// >>> bench/dpc_clock_control_tb.sv
// testbench: register-level scenarios for the clock control block
module dpc_clock_control_tb import dpc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic                           core_clk;
  logic                           sys_rst;
  logic                           clkEn;
  dpc_wb_req_t                    wbReq;
  logic                           wbAck;
  logic [31:0]                    wbDatO;
  logic signed [23:0]             ctrlDev;
  logic signed [3:0][23:0]        inputDev;
  logic signed [23:0]             holdoverFreq;
  logic signed [23:0]             localRefFreq;
  logic signed [23:0]             syncEFreq;
  logic                           ptpLinkLost;
  dpc_ts_ctl_t                    tsCtl;
  logic [31:0]                    loopBandwidth;
  logic signed [3:0][23:0]        filterInject;
  logic signed [3:0][23:0]        synthFreqOut;
  logic [3:0]                     slopeActive;
  int                             n_mismatch;
  int                             check_count;
  int                             nTime;
  int                             nPhase;
  int                             nInj[4];
  logic [31:0]                    adjSeen;
  logic [23:0]                    peak3;
  logic [31:0]                    q;
  logic                           ok;

  dpc_clock_control u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .clkEn(clkEn), .wbReq(wbReq), .wbAck(wbAck), .wbDatO(wbDatO),
    .ctrlDev(ctrlDev), .inputDev(inputDev), .holdoverFreq(holdoverFreq), .localRefFreq(localRefFreq),
    .syncEFreq(syncEFreq), .ptpLinkLost(ptpLinkLost), .tsCtl(tsCtl), .loopBandwidth(loopBandwidth),
    .filterInject(filterInject), .synthFreqOut(synthFreqOut), .slopeActive(slopeActive)
  );

  // 25 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  // strobe, inject and peak monitor, sampled at each rising edge
  always @(posedge core_clk) begin
    if (tsCtl.timeAdjStb === 1'b1) nTime++;
    if (tsCtl.phaseAdjStb === 1'b1) nPhase++;
    if ((tsCtl.timeAdjStb | tsCtl.phaseAdjStb) === 1'b1) adjSeen = tsCtl.adjVal;
    for (int i = 0; i < 4; i++) if (filterInject[i] !== 24'h00_0000) nInj[i]++;
    if (synthFreqOut[3] > peak3) peak3 = synthFreqOut[3];
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("mismatches=%0d checks=%0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // classic single cycle; waits on ack, holds request until it is sampled
  task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hF, dat: d};
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    r = wbDatO;
    if (n >= 50) n_mismatch++;
    wbReq.cyc <= 1'b0;
    wbReq.stb <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    xfer(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    xfer(1'b0, a, 32'h0000_0000, r);
    chk(r, e);
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // watchdog: the whole sequence needs well under 2000 cycles
  initial begin
    #(40 * 20000);
    n_mismatch++;
    summarize();
  end

  // main sequence
  initial begin
    sys_rst = 1'b1;
    clkEn = 1'b1;
    wbReq = '0;
    ctrlDev = '0;
    inputDev = '0;
    holdoverFreq = '0;
    localRefFreq = '0;
    syncEFreq = '0;
    ptpLinkLost = 1'b0;
    n_mismatch = 0;
    check_count = 0;
    nTime = 0;
    nPhase = 0;
    nInj = '{0, 0, 0, 0};
    peak3 = '0;
    tick(6);
    sys_rst <= 1'b0;
    tick(1);
    rd(LOOP_BW_OFS, LOOP_BW_RESET);
    rd(SLOPE_BASE_OFS, 32'(SLOPE_RESET));
    rd(CLK_SEL_OFS, 32'h0000_0000);
    // bandwidth clamps at both ends of its range
    wr(LOOP_BW_OFS, 32'h0000_0000);
    rd(LOOP_BW_OFS, LOOP_BW_MIN);
    wr(LOOP_BW_OFS, 32'hFFFF_FFFF);
    chk(loopBandwidth, LOOP_BW_MAX);
    wr(LOOP_BW_OFS, 32'h0000_2710);
    chk(loopBandwidth, 32'h0000_2710);
    wr(8'hFC, 32'hA5A5_A5A5);
    rd(8'hFC, 32'h0000_0000);
    // every source and mode pair; illegal ones are rejected whole
    for (int s = 0; s < 4; s++) begin
      for (int m = 0; m < 4; m++) begin
        ok = (s == 0 && m == 0) || (s == 1 && m == 1) || s == 2;
        wr(CLK_SEL_OFS, 32'(m * 4 + s));
        xfer(1'b0, STATUS_OFS, 32'h0000_0000, q);
        chk(32'(q[3]), 32'(!ok));
        if (ok) chk(32'({tsCtl.clkSel, tsCtl.tsMode, tsCtl.rateEn}), 32'(s * 8 + m * 2 + (m == 1)));
      end
    end
    rd(CLK_SEL_OFS, 32'h0000_000E);
    // ensemble with the timing link lost falls back on both references
    syncEFreq <= 24'sd40;
    localRefFreq <= 24'sd20;
    ptpLinkLost <= 1'b1;
    tick(4);
    chk(32'(synthFreqOut[1]), 32'h0000_001E);
    ptpLinkLost <= 1'b0;
    syncEFreq <= '0;
    localRefFreq <= '0;
    wr(TS_ADJ_OFS, 32'h0000_1234);
    tick(3);
    chk(32'(nPhase), 32'h0000_0001);
    chk(adjSeen, 32'h0000_1234);
    wr(CLK_SEL_OFS, 32'h0000_0000);
    wr(TS_ADJ_OFS, 32'h0000_5678);
    tick(3);
    chk(32'(nTime), 32'h0000_0001);
    chk(adjSeen, 32'h0000_5678);
    wr(CLK_SEL_OFS, 32'h0000_0005);
    wr(TS_RATE_OFS, 32'h0001_0000);
    chk(tsCtl.rateCorr, 32'h0001_0000);
    // limits 16, 16 with build-out, and reset 100 on synth 2
    wr(SLOPE_BASE_OFS, 32'h0000_0024);
    wr(SLOPE_BASE_OFS + 8'h04, 32'h0000_0424);
    for (int i = 0; i < 3; i++) wr(SRC_BASE_OFS + 8'(4 * i), 32'h0000_0002);
    ctrlDev <= 24'sd1000;
    tick(6);
    chk(32'(synthFreqOut[0]), 32'h0000_0010);
    chk(32'(synthFreqOut[2]), 32'h0000_0064);
    chk(32'(slopeActive[2:0]), 32'h0000_0007);
    ctrlDev <= '0;
    tick(4);
    chk(32'(synthFreqOut[0]), 32'h0000_0010);
    chk(32'(synthFreqOut[1]), 32'h0000_0000);
    // per-synth dco and direct input lock past the limiter
    wr(DCO_BASE_OFS + 8'h0C, 32'h0000_0005);
    wr(DCO_BASE_OFS + 8'h08, 32'h0000_0003);
    wr(DCO_BASE_OFS, 32'h0000_0002);
    tick(3);
    chk(32'(synthFreqOut[3]), 32'h0000_0005);
    chk(32'(synthFreqOut[0]), 32'h0000_0012);
    inputDev[2] <= 24'sd5000;
    wr(SRC_BASE_OFS + 8'h0C, 32'h0000_0009);
    tick(3);
    chk(32'(synthFreqOut[3]), 32'h0000_138D);
    wr(SRC_BASE_OFS + 8'h0C, 32'h0000_0000);
    inputDev <= '0;
    tick(3);
    // mode a on synths 0 and 2, held 3+1 cycles
    wr(PS_TIMER_OFS, 32'h0000_0003);
    nInj = '{0, 0, 0, 0};
    wr(PS_MAIN_OFS, 32'h0007_0052);
    tick(12);
    chk(32'(nInj[0]), 32'h0000_0004);
    chk(32'(nInj[2]), 32'h0000_0004);
    chk(32'(nInj[1]), 32'h0000_0000);
    // mode b on synth 3: two steps of 10 over a dco base of 5
    wr(PS_TIMER_OFS, 32'h0200_0001);
    peak3 = '0;
    nInj = '{0, 0, 0, 0};
    wr(PS_MAIN_OFS, 32'h000A_0083);
    tick(20);
    chk(32'(peak3), 32'h0000_0019);
    chk(32'(nInj[3]), 32'h0000_0000);
    chk(32'(synthFreqOut[3]), 32'h0000_0005);
    xfer(1'b0, STATUS_OFS, 32'h0000_0000, q);
    chk(32'(q[1:0]), 32'h0000_0000);
    summarize();
  end
endmodule // dpc_clock_control_tb

// >>> core/dpc_clock_control.sv
// timestamp clock select, dpll loop filter, slope limit, phase shift and dco control
// Function
// - timestamp clock from line, secondary, synth2
// - hybrid: syncE rate, software-written time corrections
// - software rate mode applies programmed rate correction
// - dco mode steers synth2 frequency, phase adjust
// - ensemble: dco, fallback to mean of syncE and local reference when link lost
// - only legal source and mode pairs accepted
// - loop bandwidth held within 0.35 mHz..33 kHz
// - slope limiter bounds deviation versus chosen reference
// - slope limit is mantissa times two^exponent
// - without build-out original phase is restored
// - with build-out input phase step discarded
// - per-synthesizer slope limit and build-out config
// - mode A injects offset at filter input
// - mode B ramps up, holds, ramps down, unfiltered
// - mode and timer configs, selected synths together
// - per-synth dco offset added in every source mode
// - one independent dco controller per synthesizer
// - synthesizer may lock directly to input clock
//
// Our own choices: the Wishbone register port and the placing of the registers.
module dpc_clock_control import dpc_pkg::*; #(
  parameter int NSYN = 4,
  parameter int NINP = 4,
  parameter int DW   = 24
) (
  // clock, reset, clock enable
  input  wire logic                           core_clk,
  input  wire logic                           sys_rst,
  input  wire logic                           clkEn,
  // wishbone slave
  input  wire dpc_wb_req_t                    wbReq,
  output logic                                wbAck,
  output logic [31:0]                         wbDatO,
  // frequency deviations seen by the synthesizers
  input  wire logic signed [DW-1:0]           ctrlDev,
  input  wire logic signed [NINP-1:0][DW-1:0] inputDev,
  input  wire logic signed [DW-1:0]           holdoverFreq,
  input  wire logic signed [DW-1:0]           localRefFreq,
  input  wire logic signed [DW-1:0]           syncEFreq,
  input  wire logic                           ptpLinkLost,
  // timestamp block control
  output dpc_ts_ctl_t                         tsCtl,
  // loop filter and synthesizer controls
  output logic [31:0]                         loopBandwidth,
  output logic signed [NSYN-1:0][DW-1:0]      filterInject,
  output logic signed [NSYN-1:0][DW-1:0]      synthFreqOut,
  output logic [NSYN-1:0]                     slopeActive
);

  // synth2 drives the timestamp clock
  localparam int SYN2 = 1;

  typedef struct packed {
    logic                           ack;
    logic [31:0]                    rdat;
    dpc_clk_src_t                   clkSrc;
    dpc_ts_mode_t                   tsMode;
    logic                           selRejected;
    logic [31:0]                    rateCorr;
    logic [31:0]                    adjVal;
    logic                           timeAdjStb;
    logic                           phaseAdjStb;
    logic [31:0]                    loopBw;
    logic [NSYN-1:0][11:0]          slopeCfg;
    logic [NSYN-1:0][3:0]           synSrc;
    logic signed [NSYN-1:0][DW-1:0] dco;
    logic [31:0]                    psMain;
    logic [31:0]                    psTimer;
    dpc_ps_state_t                  psState;
    logic signed [DW-1:0]           psLevel;
    logic [23:0]                    psCount;
    logic [7:0]                     psSteps;
    logic signed [NSYN-1:0][DW-1:0] freq;
    logic signed [NSYN-1:0][DW-1:0] inject;
  } dpc_state_t;

  dpc_state_t stQ, stD;

  logic signed [NSYN-1:0][DW-1:0] slDevIn, slDevOut;
  logic [NSYN-1:0]                slAct;

  // legal pairs of timestamp clock source and operating mode
  function automatic logic modeLegal(input logic [1:0] src, input logic [1:0] mode);
    case (src)
      SRC_LINE_PLL: modeLegal = (mode == TS_HYBRID);
      SRC_SEC_PLL:  modeLegal = (mode == TS_SW_RATE);
      SRC_SYNTH2:   modeLegal = 1'b1;
      default:      modeLegal = 1'b0;
    endcase
  endfunction

  // byte-lane merge of a write into a stored word
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      laneMerge[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
  endfunction

  // hit on one synthesizer's copy of a per-synthesizer register
  function automatic logic synHit(input logic [7:0] adr, input logic [7:0] base, input int s);
    synHit = (adr == base + 8'(s) * SYNTH_STRIDE);
  endfunction

  // per-synthesizer slope limiters, each with its own configuration
  generate
    for (genvar s = 0; s < NSYN; s++) begin : g_syn
      dpc_slope_limit #(
        .DW(DW)
      ) u_slope (
        .core_clk        (core_clk),
        .sys_rst         (sys_rst),
        .clkEn           (clkEn),
        .slopeLimitField (stQ.slopeCfg[s][9:0]),
        .buildOutEn      (stQ.slopeCfg[s][BUILD_OUT_BIT]),
        .devIn           (slDevIn[s]),
        .devOut          (slDevOut[s]),
        .limitActive     (slAct[s])
      );
    end
  endgenerate

  // limiter input: deviation against holdover or local reference
  // both references arrive filtered; no smoothing here
  always_comb begin
    for (int s = 0; s < NSYN; s++) begin
      slDevIn[s] = ctrlDev - (stQ.slopeCfg[s][SLOPE_REF_BIT] ? localRefFreq : holdoverFreq);
    end
  end

  // register access, phase shift generator and synthesizer frequency
  always_comb begin
    logic [7:0]           a;
    logic [31:0]          wv;
    logic                 wr;
    logic                 legal;
    logic                 psModeB;
    logic signed [DW-1:0] step;
    logic signed [DW-1:0] base;
    logic signed [DW-1:0] shift;
    logic [1:0]           inp;
    a = wbReq.adr;
    wv = 32'h0000_0000;
    wr = 1'b0;
    legal = 1'b0;
    psModeB = stQ.psMain[PS_MODE_BIT];
    step = DW'(signed'(stQ.psMain[PS_STEP_LSB +: 16]));
    base = '0;
    shift = '0;
    inp = '0;
    stD = stQ;
    stD.ack = 1'b0;
    stD.timeAdjStb = 1'b0;
    stD.phaseAdjStb = 1'b0;

    // wishbone: one ack per request, dropped the cycle after
    if (wbReq.cyc && wbReq.stb && !stQ.ack) begin
      // registered ack: a request held over the ack edge is not taken twice
      stD.ack = 1'b1;
      stD.rdat = 32'h0000_0000;
      case (a)
        CLK_SEL_OFS: stD.rdat = {28'h000_0000, stQ.tsMode, stQ.clkSrc};
        TS_RATE_OFS: stD.rdat = stQ.rateCorr;
        TS_ADJ_OFS:  stD.rdat = stQ.adjVal;
        LOOP_BW_OFS: stD.rdat = stQ.loopBw;
        PS_MAIN_OFS: stD.rdat = stQ.psMain & ~(32'h0000_0001 << PS_START_BIT);
        PS_TIMER_OFS: stD.rdat = stQ.psTimer;
        STATUS_OFS: begin
          // read-only; [7:4] stay clear
          stD.rdat = {20'h0_0000, 4'(slAct), 4'h0, stQ.selRejected,
                      modeLegal(stQ.clkSrc, stQ.tsMode), stQ.psState};
        end
        default: begin
          // per-synthesizer registers repeat at one stride
          for (int s = 0; s < NSYN; s++) begin
            if (synHit(a, SLOPE_BASE_OFS, s))
              stD.rdat = {20'h0_0000, stQ.slopeCfg[s]};
            if (synHit(a, SRC_BASE_OFS, s))
              stD.rdat = {28'h000_0000, stQ.synSrc[s]};
            if (synHit(a, DCO_BASE_OFS, s))
              stD.rdat = 32'(stQ.dco[s]);
          end
        end
      endcase
    end
    // writes commit at the ack edge, while the master still holds the request
    wr = wbReq.cyc && wbReq.stb && wbReq.we && stQ.ack;

    // register writes; unmapped addresses are acked and dropped
    if (wr) begin
      case (a)
        CLK_SEL_OFS: begin
          wv = laneMerge({28'h000_0000, stQ.tsMode, stQ.clkSrc}, wbReq.dat, wbReq.sel);
          // an illegal pair leaves the previous selection in force
          legal = modeLegal(wv[CLK_SRC_LSB +: 2], wv[TS_MODE_LSB +: 2]);
          stD.selRejected = !legal;
          if (legal) begin
            stD.clkSrc = dpc_clk_src_t'(wv[CLK_SRC_LSB +: 2]);
            stD.tsMode = dpc_ts_mode_t'(wv[TS_MODE_LSB +: 2]);
          end
        end
        TS_RATE_OFS: stD.rateCorr = laneMerge(stQ.rateCorr, wbReq.dat, wbReq.sel);
        TS_ADJ_OFS: begin
          stD.adjVal = laneMerge(stQ.adjVal, wbReq.dat, wbReq.sel);
          // hybrid corrects time directly, dco modes nudge the phase
          stD.timeAdjStb = (stQ.tsMode == TS_HYBRID) || (stQ.tsMode == TS_SW_RATE);
          stD.phaseAdjStb = (stQ.tsMode == TS_DCO) || (stQ.tsMode == TS_ENSEMBLE);
        end
        LOOP_BW_OFS: begin
          wv = laneMerge(stQ.loopBw, wbReq.dat, wbReq.sel);
          // clamp, not reject: software always gets a usable filter
          if (wv < LOOP_BW_MIN)
            stD.loopBw = LOOP_BW_MIN;
          else if (wv > LOOP_BW_MAX)
            stD.loopBw = LOOP_BW_MAX;
          else
            stD.loopBw = wv;
        end
        PS_MAIN_OFS: begin
          wv = laneMerge(stQ.psMain, wbReq.dat, wbReq.sel);
          stD.psMain = wv;
          // start only from idle; a shift in flight runs to its end
          if (wv[PS_START_BIT] && stQ.psState == PS_IDLE) begin
            stD.psSteps = 8'h00;
            stD.psCount = stQ.psTimer[PS_DUR_LSB +: 24];
            if (wv[PS_MODE_BIT]) begin
              stD.psState = PS_RAMPU;
              stD.psLevel = '0;
            end else begin
              stD.psState = PS_HOLD;
              stD.psLevel = DW'(signed'(wv[PS_STEP_LSB +: 16]));
            end
          end
        end
        // a running up-ramp sees a new step count at once, the down-ramp does not; program before start
        PS_TIMER_OFS: stD.psTimer = laneMerge(stQ.psTimer, wbReq.dat, wbReq.sel);
        default: begin
          for (int s = 0; s < NSYN; s++) begin
            if (synHit(a, SLOPE_BASE_OFS, s))
              stD.slopeCfg[s] = 12'(laneMerge(32'(stQ.slopeCfg[s]), wbReq.dat, wbReq.sel));
            if (synHit(a, SRC_BASE_OFS, s))
              stD.synSrc[s] = 4'(laneMerge(32'(stQ.synSrc[s]), wbReq.dat, wbReq.sel));
            if (synHit(a, DCO_BASE_OFS, s))
              stD.dco[s] = DW'(laneMerge(32'(stQ.dco[s]), wbReq.dat, wbReq.sel));
          end
        end
      endcase
    end

    // phase shift sequencer; ramps take psTimer steps of one step each
    // the step count is eight bits, so a ramp has at most 255 steps
    case (stQ.psState)
      PS_IDLE: begin
        // a start written this cycle has already loaded the level
        if (stD.psState == PS_IDLE)
          stD.psLevel = '0;
      end
      PS_RAMPU: begin
        if (stQ.psSteps == stQ.psTimer[PS_STEPS_LSB +: 8]) begin
          stD.psState = PS_HOLD;
        end else begin
          stD.psLevel = stQ.psLevel + step;
          stD.psSteps = stQ.psSteps + 8'h01;
        end
      end
      PS_HOLD: begin
        if (stQ.psCount == 24'h00_0000) begin
          if (psModeB) begin
            stD.psState = PS_RAMPD;
          end else begin
            stD.psState = PS_IDLE;
            stD.psLevel = '0;
          end
        end else begin
          stD.psCount = stQ.psCount - 24'h00_0001;
        end
      end
      PS_RAMPD: begin
        if (stQ.psSteps == 8'h00) begin
          stD.psState = PS_IDLE;
          stD.psLevel = '0;
        end else begin
          stD.psLevel = stQ.psLevel - step;
          stD.psSteps = stQ.psSteps - 8'h01;
        end
      end
      default: stD.psState = PS_IDLE;
    endcase

    // synthesizer frequency: reference, own dco, phase shift
    for (int s = 0; s < NSYN; s++) begin
      shift = stQ.psMain[PS_SEL_LSB + s] ? stQ.psLevel : '0;
      inp = stQ.synSrc[s][SYN_INP_LSB +: 2];
      // direct input lock skips the limiter: input steps pass unbounded
      case (dpc_syn_src_t'(stQ.synSrc[s][SYN_SRC_LSB +: 2]))
        SYN_FREE_RUN: base = '0;
        SYN_INPUT:    base = inputDev[inp];
        SYN_CTRL:     base = slDevOut[s];
        default:      base = '0;
      endcase
      // ensemble with the timing link lost falls back to the mean of syncE and local reference
      if (s == SYN2 && stQ.tsMode == TS_ENSEMBLE && ptpLinkLost)
        base = DW'(((DW+1)'(syncEFreq) + (DW+1)'(localRefFreq)) >>> 1);
      // the timestamp clock is steered through synth2's own dco
      stD.freq[s] = base + stQ.dco[s] + ((psModeB && stQ.psState != PS_IDLE) ? shift : '0);
      // mode A moves only the filter input; the filter shapes the output
      stD.inject[s] = (!psModeB && stQ.psState == PS_HOLD) ? shift : '0;
    end
  end

  // single state register, frozen while the clock enable is low
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      // reset gives 3 Hz bandwidth and a 100 ppb slope
      stQ <= '0;
      stQ.loopBw <= LOOP_BW_RESET;
      for (int s = 0; s < NSYN; s++) begin
        stQ.slopeCfg[s] <= {2'b00, SLOPE_RESET};
      end
    end else if (clkEn) begin
      stQ <= stD;
    end
  end

  // outputs
  assign wbAck = stQ.ack;
  assign wbDatO = stQ.rdat;
  assign tsCtl.clkSel = stQ.clkSrc;
  assign tsCtl.tsMode = stQ.tsMode;
  // rate correction applies only in rate-control mode
  assign tsCtl.rateEn = (stQ.tsMode == TS_SW_RATE);
  assign tsCtl.rateCorr = stQ.rateCorr;
  assign tsCtl.timeAdjStb = stQ.timeAdjStb;
  assign tsCtl.phaseAdjStb = stQ.phaseAdjStb;
  assign tsCtl.adjVal = stQ.adjVal;
  assign loopBandwidth = stQ.loopBw;
  assign filterInject = stQ.inject;
  assign synthFreqOut = stQ.freq;
  assign slopeActive = slAct;

endmodule // dpc_clock_control

// >>> core/dpc_pkg.sv
// package: register map, field layout, reset values and encodings of the clock control block
package dpc_pkg;

  // register byte offsets on the wishbone slave
  localparam logic [7:0] CLK_SEL_OFS    = 8'h00;
  localparam logic [7:0] TS_RATE_OFS    = 8'h04;
  localparam logic [7:0] TS_ADJ_OFS     = 8'h08;
  localparam logic [7:0] LOOP_BW_OFS    = 8'h0C;
  localparam logic [7:0] SLOPE_BASE_OFS = 8'h10;
  localparam logic [7:0] SRC_BASE_OFS   = 8'h20;
  localparam logic [7:0] DCO_BASE_OFS   = 8'h30;
  localparam logic [7:0] PS_MAIN_OFS    = 8'h40;
  localparam logic [7:0] PS_TIMER_OFS   = 8'h44;
  localparam logic [7:0] STATUS_OFS     = 8'h48;
  localparam logic [7:0] SYNTH_STRIDE   = 8'h04;

  // clock source select field
  localparam int CLK_SRC_LSB  = 0;
  localparam int TS_MODE_LSB  = 2;
  // slope limit config field: [9:5] mantissa, [4:0] exponent
  localparam int SLOPE_EXP_LSB  = 0;
  localparam int SLOPE_MANT_LSB = 5;
  localparam int BUILD_OUT_BIT  = 10;
  localparam int SLOPE_REF_BIT  = 11;
  // synthesizer source config field
  localparam int SYN_SRC_LSB = 0;
  localparam int SYN_INP_LSB = 2;
  // phase shift main config field
  localparam int PS_MODE_BIT  = 0;
  localparam int PS_START_BIT = 1;
  localparam int PS_SEL_LSB   = 4;
  localparam int PS_STEP_LSB  = 16;
  // phase shift timer config field
  localparam int PS_DUR_LSB   = 0;
  localparam int PS_STEPS_LSB = 24;

  // loop filter bandwidth in units of 0.01 mHz: 0.35 mHz .. 33 kHz, reset 3 Hz
  localparam logic [31:0] LOOP_BW_MIN   = 32'h0000_0023;
  localparam logic [31:0] LOOP_BW_MAX   = 32'hC4B2_0100;
  localparam logic [31:0] LOOP_BW_RESET = 32'h0004_93E0;

  // slope limit reset: 25 x 2^2 = 100 ppb
  localparam logic [9:0] SLOPE_RESET = 10'h322;

  typedef enum logic [1:0] {
    SRC_LINE_PLL = 2'b00,
    SRC_SEC_PLL  = 2'b01,
    SRC_SYNTH2   = 2'b10
  } dpc_clk_src_t;

  typedef enum logic [1:0] {
    TS_HYBRID   = 2'b00,
    TS_SW_RATE  = 2'b01,
    TS_DCO      = 2'b10,
    TS_ENSEMBLE = 2'b11
  } dpc_ts_mode_t;

  // synthesizer reference: free-run/dco, direct input clock, selection controller
  typedef enum logic [1:0] {
    SYN_FREE_RUN = 2'b00,
    SYN_INPUT    = 2'b01,
    SYN_CTRL     = 2'b10
  } dpc_syn_src_t;

  typedef enum logic [1:0] {
    PS_IDLE  = 2'b00,
    PS_RAMPU = 2'b01,
    PS_HOLD  = 2'b10,
    PS_RAMPD = 2'b11
  } dpc_ps_state_t;

  // wishbone request from the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } dpc_wb_req_t;

  // timestamp block control
  typedef struct packed {
    dpc_clk_src_t clkSel;
    dpc_ts_mode_t tsMode;
    logic         rateEn;
    logic [31:0]  rateCorr;
    logic         timeAdjStb;
    logic         phaseAdjStb;
    logic [31:0]  adjVal;
  } dpc_ts_ctl_t;

endpackage : dpc_pkg

// >>> core/dpc_slope_limit.sv
// phase slope limiter with optional phase build-out for one synthesizer
module dpc_slope_limit import dpc_pkg::*; #(
  parameter int DW = 24
) (
  // clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clkEn,
  // configuration
  input  wire logic [9:0]           slopeLimitField,
  input  wire logic                 buildOutEn,
  // deviation in and limited deviation out
  input  wire logic signed [DW-1:0] devIn,
  output logic signed [DW-1:0]      devOut,
  output logic                      limitActive
);

  typedef struct packed {
    logic signed [DW+1:0] owed;
    logic signed [DW-1:0] out;
    logic                 active;
  } dpc_sl_state_t;

  dpc_sl_state_t stQ, stD;
  logic [36:0]          limWide;
  logic signed [DW+1:0] lim, want, clamped;

  // limit = mantissa * 2^exponent, saturated to the deviation range
  always_comb begin
    limWide = 37'(slopeLimitField[SLOPE_MANT_LSB +: 5]) << slopeLimitField[SLOPE_EXP_LSB +: 5];
    if (limWide > 37'((1 << (DW - 1)) - 1))
      lim = (DW+2)'((1 << (DW - 1)) - 1);
    else
      lim = (DW+2)'(limWide);
  end

  // owed phase is replayed only when build-out is off
  always_comb begin
    stD = stQ;
    want = (DW+2)'(devIn) + (buildOutEn ? '0 : stQ.owed);
    if (want > lim)
      clamped = lim;
    else if (want < -lim)
      clamped = -lim;
    else
      clamped = want;
    stD.out = DW'(clamped);
    stD.active = (want != clamped);
    // build-out drops the clipped phase instead of keeping it
    stD.owed = buildOutEn ? '0 : (want - clamped);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)
      stQ <= '0;
    else if (clkEn)
      stQ <= stD;
  end

  assign devOut = stQ.out;
  assign limitActive = stQ.active;

endmodule // dpc_slope_limit
